/* core/cgr_pkg.sv */
// Package with the register map, reset values, field layout and carrier types of the calibration and pin bank
// Behaviour
// - Offset trim is 24 bits over three byte registers; low, mid and top reset zero.
// - Gain trim is 24 bits at consecutive bytes, resets low zero, mid zero, top 40h.
// - Pin data bits 7:4 set direction per pin, 0 output, 1 input, reset outputs.
// - Pin data bits 3:0 hold level; digital outputs drive written value, inputs report sensed level.
// - Pin configuration bits 3:0 pick analog or digital use; bits 7:4 read zero.
package cgr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RES_W = 24;
  localparam int PIN_N = 4;

  localparam logic [7:0] ADDR_OFFSET_CAL_LOW = 8'h0A;
  localparam logic [7:0] ADDR_OFFSET_CAL_MID = 8'h0B;
  localparam logic [7:0] ADDR_OFFSET_CAL_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_GAIN_CAL_LOW = 8'h0D;
  localparam logic [7:0] ADDR_GAIN_CAL_MID = 8'h0E;
  localparam logic [7:0] ADDR_GAIN_CAL_HIGH = 8'h0F;
  localparam logic [7:0] ADDR_PIN_DIR_AND_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_PIN_FUNCTION_SELECT_REG = 8'h11;

  localparam logic [7:0] RST_OFFSET_CAL_LOW = 8'h00;
  localparam logic [7:0] RST_OFFSET_CAL_MID = 8'h00;
  localparam logic [7:0] RST_OFFSET_CAL_HIGH = 8'h00;
  localparam logic [7:0] RST_GAIN_CAL_LOW = 8'h00;
  localparam logic [7:0] RST_GAIN_CAL_MID = 8'h00;
  localparam logic [7:0] RST_GAIN_CAL_HIGH = 8'h40;
  localparam logic [3:0] RST_PIN_DIR = 4'h0;
  localparam logic [3:0] RST_PIN_LEVEL = 4'h0;
  localparam logic [3:0] RST_PIN_FUNCTION = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int PIN_LEVEL_LSB = 0;
  localparam int PIN_DIR_LSB = 4;
  localparam int PIN_FUNC_LSB = 0;
  localparam logic [3:0] FUNC_RESERVED_READ = 4'h0;

  // Gain trim of 40_0000h means a factor of one, so the product is shifted down by 22
  localparam int GAIN_UNITY_SHIFT = 22;
  localparam logic [23:0] GAIN_UNITY = 24'h400000;
  localparam int CORR_LATENCY = 2;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cgr_bus_req_type;

  typedef struct packed {
    logic [23:0] offset_trim_value;
    logic [23:0] gain_trim_value;
  } cgr_trim_type;

  typedef struct packed {
    logic valid;
    logic [23:0] value;
  } cgr_sample_type;
endpackage : cgr_pkg

/* core/cgr_pin_cell.sv */
// One general-purpose pin: input synchroniser and drive control
`timescale 1ns/1ps
module cgr_pin_cell (
  input wire logic clock, // Device clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic pad_in, // Level sensed on the pin
  input wire logic func_digital, // Pin assigned to digital use
  input wire logic dir_input, // Pin is an input
  input wire logic level_out, // Level to drive when an output
  output logic pad_out, // Level driven onto the pin
  output logic pad_oe, // High while the pin is driven
  output logic sensed // Synchronised pin level
);
  logic sync_first;
  logic sync_second;

  // Pin is asynchronous to the clock; only the second stage is read
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
    end
    else
    begin
      sync_first <= pad_in;
      sync_second <= sync_first;
    end
  end

  assign sensed = sync_second;
  assign pad_out = level_out;
  // An analog pin is never driven, whatever the direction bit says
  assign pad_oe = func_digital & ~dir_input;
endmodule : cgr_pin_cell

/* core/cgr_regs.sv */
// Calibration trim and general-purpose pin register bank with the trim correction path
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module cgr_regs #(
  parameter int PIN_N = 4
) (
  input wire logic clock, // Device clock, 25 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire cgr_pkg::cgr_bus_req_type bus_req, // Register address, write data and strobes
  output logic [7:0] bus_rdata, // Read data, valid the cycle after a read strobe
  input wire logic [PIN_N-1:0] pin_in, // Levels sensed on the pins
  output logic [PIN_N-1:0] pin_out, // Levels driven onto the pins
  output logic [PIN_N-1:0] pin_oe, // High while a pin is driven
  output logic [PIN_N-1:0] pin_analog_en, // High where a pin serves as analog input
  input wire cgr_pkg::cgr_sample_type raw_sample, // Raw conversion result, signed
  output cgr_pkg::cgr_sample_type corr_sample, // Corrected conversion result, signed
  output cgr_pkg::cgr_trim_type trim // Current trim values
);
  logic [7:0] offset_cal_low;
  logic [7:0] offset_cal_mid;
  logic [7:0] offset_cal_high;
  logic [7:0] gain_cal_low;
  logic [7:0] gain_cal_mid;
  logic [7:0] gain_cal_high;
  logic [PIN_N-1:0] pin_dir;
  logic [PIN_N-1:0] pin_level_bits;
  logic [PIN_N-1:0] pin_function_select;
  logic [PIN_N-1:0] pin_sensed;
  logic [PIN_N-1:0] level_view;
  logic [7:0] next_rdata;
  logic [23:0] offset_trim_value;
  logic [23:0] gain_trim_value;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;

  assign wr = bus_req.wr;
  assign rd = bus_req.rd;
  assign addr = bus_req.addr;
  assign wdata = bus_req.wdata;

  assign offset_trim_value = {offset_cal_high, offset_cal_mid, offset_cal_low};
  assign gain_trim_value = {gain_cal_high, gain_cal_mid, gain_cal_low};
  assign trim = {offset_trim_value, gain_trim_value};

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      offset_cal_low <= cgr_pkg::RST_OFFSET_CAL_LOW;
      offset_cal_mid <= cgr_pkg::RST_OFFSET_CAL_MID;
      offset_cal_high <= cgr_pkg::RST_OFFSET_CAL_HIGH;
    end
    else if (wr)
    begin
      if (addr == cgr_pkg::ADDR_OFFSET_CAL_LOW)
        offset_cal_low <= wdata;
      if (addr == cgr_pkg::ADDR_OFFSET_CAL_MID)
        offset_cal_mid <= wdata;
      if (addr == cgr_pkg::ADDR_OFFSET_CAL_HIGH)
        offset_cal_high <= wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      gain_cal_low <= cgr_pkg::RST_GAIN_CAL_LOW;
      gain_cal_mid <= cgr_pkg::RST_GAIN_CAL_MID;
      gain_cal_high <= cgr_pkg::RST_GAIN_CAL_HIGH;
    end
    else if (wr)
    begin
      if (addr == cgr_pkg::ADDR_GAIN_CAL_LOW)
        gain_cal_low <= wdata;
      if (addr == cgr_pkg::ADDR_GAIN_CAL_MID)
        gain_cal_mid <= wdata;
      if (addr == cgr_pkg::ADDR_GAIN_CAL_HIGH)
        gain_cal_high <= wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pin_dir <= cgr_pkg::RST_PIN_DIR;
      pin_level_bits <= cgr_pkg::RST_PIN_LEVEL;
    end
    else if (wr && addr == cgr_pkg::ADDR_PIN_DIR_AND_LEVEL)
    begin
      pin_dir <= wdata[cgr_pkg::PIN_DIR_LSB +: PIN_N];
      // Level bits of input pins are stored but not driven until the pin turns to output
      pin_level_bits <= wdata[cgr_pkg::PIN_LEVEL_LSB +: PIN_N];
    end
  end

  // Upper bits of the configuration write are dropped; they have no storage
  always_ff @(posedge clock)
  begin
    if (!resetn)
      pin_function_select <= cgr_pkg::RST_PIN_FUNCTION;
    else if (wr && addr == cgr_pkg::ADDR_PIN_FUNCTION_SELECT_REG)
      pin_function_select <= wdata[cgr_pkg::PIN_FUNC_LSB +: PIN_N];
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_pin
      cgr_pin_cell u_pin (
        .clock(clock),
        .resetn(resetn),
        .pad_in(pin_in[gi]),
        .func_digital(pin_function_select[gi]),
        .dir_input(pin_dir[gi]),
        .level_out(pin_level_bits[gi]),
        .pad_out(pin_out[gi]),
        .pad_oe(pin_oe[gi]),
        .sensed(pin_sensed[gi])
      );
    end
  endgenerate

  // Software must enable a pin before it leaves analog use; the default keeps it analog
  assign pin_analog_en = ~pin_function_select;

  // Inputs report the sensed level, outputs the written value
  assign level_view = (pin_dir & pin_sensed) | (~pin_dir & pin_level_bits);

  always_comb
  begin
    next_rdata = cgr_pkg::READ_UNMAPPED;
    case (addr)
      cgr_pkg::ADDR_OFFSET_CAL_LOW: next_rdata = offset_cal_low;
      cgr_pkg::ADDR_OFFSET_CAL_MID: next_rdata = offset_cal_mid;
      cgr_pkg::ADDR_OFFSET_CAL_HIGH: next_rdata = offset_cal_high;
      cgr_pkg::ADDR_GAIN_CAL_LOW: next_rdata = gain_cal_low;
      cgr_pkg::ADDR_GAIN_CAL_MID: next_rdata = gain_cal_mid;
      cgr_pkg::ADDR_GAIN_CAL_HIGH: next_rdata = gain_cal_high;
      cgr_pkg::ADDR_PIN_DIR_AND_LEVEL: next_rdata = {pin_dir, level_view};
      cgr_pkg::ADDR_PIN_FUNCTION_SELECT_REG: next_rdata = {cgr_pkg::FUNC_RESERVED_READ, pin_function_select};
      default: next_rdata = cgr_pkg::READ_UNMAPPED;
    endcase
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge clock)
  begin
    if (!resetn)
      bus_rdata <= cgr_pkg::READ_UNMAPPED;
    else if (rd)
      bus_rdata <= next_rdata;
    else
      bus_rdata <= cgr_pkg::READ_UNMAPPED;
  end

  // Correction path: stage one removes the offset, stage two scales by the gain
  logic diff_valid;
  logic signed [24:0] diff;
  logic signed [49:0] product;
  logic signed [49:0] scaled;
  logic fits;
  logic [23:0] next_corr;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      diff_valid <= 1'b0;
      diff <= '0;
    end
    else
    begin
      diff_valid <= raw_sample.valid;
      if (raw_sample.valid)
        diff <= $signed({raw_sample.value[23], raw_sample.value})
          - $signed({offset_trim_value[23], offset_trim_value});
    end
  end

  // Gain trim is unsigned; the zero top bit keeps it positive in the signed product
  assign product = diff * $signed({1'b0, gain_trim_value});
  assign scaled = product >>> cgr_pkg::GAIN_UNITY_SHIFT;
  assign fits = (scaled[49:23] == {27{scaled[23]}});

  // Results beyond 24 bits clip to full scale rather than wrap
  always_comb
  begin
    if (fits)
      next_corr = scaled[23:0];
    else if (scaled[49])
      next_corr = 24'h800000;
    else
      next_corr = 24'h7FFFFF;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      corr_sample.valid <= 1'b0;
      corr_sample.value <= '0;
    end
    else
    begin
      corr_sample.valid <= diff_valid;
      if (diff_valid)
        corr_sample.value <= next_corr;
    end
  end

  AST_OFFSET_RESET: assert property (@(posedge clock) !resetn |=> offset_trim_value == 24'h000000)
    else $error("offset trim not zero after reset");

  AST_OFFSET_HIGH_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_OFFSET_CAL_HIGH |=> offset_trim_value[23:16] == $past(wdata))
    else $error("offset top byte did not take the write");

  AST_GAIN_RESET: assert property (@(posedge clock) !resetn |=> gain_trim_value == 24'h400000)
    else $error("gain trim not 400000h after reset");

  AST_GAIN_READBACK: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_GAIN_CAL_MID ##1 rd && addr == cgr_pkg::ADDR_GAIN_CAL_MID
    |=> bus_rdata == $past(wdata, 2))
    else $error("gain middle byte read back wrong");

  AST_DIR_DRIVE: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_PIN_DIR_AND_LEVEL && wdata[7:4] == 4'hF |=> pin_oe == 4'h0)
    else $error("input pin still driven");

  AST_OUT_LEVEL: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_PIN_DIR_AND_LEVEL |=> pin_out == $past(wdata[3:0]))
    else $error("pin output level differs from written value");

  AST_IN_READBACK: assert property (@(posedge clock) disable iff (!resetn)
    rd && addr == cgr_pkg::ADDR_PIN_DIR_AND_LEVEL && pin_dir == 4'hF |=> bus_rdata[3:0] == $past(pin_sensed))
    else $error("input level read back wrong");

  AST_FUNC_UPPER: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_PIN_FUNCTION_SELECT_REG ##1 rd && addr == cgr_pkg::ADDR_PIN_FUNCTION_SELECT_REG
    |=> bus_rdata == {4'h0, $past(wdata[3:0], 2)})
    else $error("configuration read back wrong");

  AST_CORR_UNITY: assert property (@(posedge clock) disable iff (!resetn)
    raw_sample.valid && gain_trim_value == 24'h400000 && offset_trim_value == 24'h000000 ##1
    gain_trim_value == 24'h400000 ##1 corr_sample.valid |-> corr_sample.value == $past(raw_sample.value, 2))
    else $error("unity trim changed the sample");

  AST_CORR_LATENCY: assert property (@(posedge clock) disable iff (!resetn)
    raw_sample.valid |-> ##2 corr_sample.valid)
    else $error("corrected sample late");

  AST_OFFSET_MID_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_OFFSET_CAL_MID |=> offset_trim_value[15:8] == $past(wdata))
    else $error("offset middle byte did not take the write");

  AST_GAIN_LOW_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_GAIN_CAL_LOW |=> gain_trim_value[7:0] == $past(wdata))
    else $error("gain low byte did not take the write");

  AST_GAIN_MID_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_GAIN_CAL_MID |=> gain_trim_value[15:8] == $past(wdata))
    else $error("gain middle byte did not take the write");

  AST_GAIN_HIGH_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_GAIN_CAL_HIGH |=> gain_trim_value[23:16] == $past(wdata))
    else $error("gain top byte did not take the write");

  AST_DIR_OUTPUT_DRIVE: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_PIN_DIR_AND_LEVEL && wdata[7:4] == 4'h0 |=> pin_oe == ~pin_analog_en)
    else $error("digital output pin not driven");

  AST_DIR_READBACK: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == cgr_pkg::ADDR_PIN_DIR_AND_LEVEL ##1 rd && addr == cgr_pkg::ADDR_PIN_DIR_AND_LEVEL
    |=> bus_rdata[7:4] == $past(wdata[7:4], 2))
    else $error("direction read back wrong");

  AST_OUT_READBACK: assert property (@(posedge clock) disable iff (!resetn)
    rd && addr == cgr_pkg::ADDR_PIN_DIR_AND_LEVEL && pin_dir == 4'h0 |=> bus_rdata[3:0] == $past(pin_level_bits))
    else $error("output level read back wrong");

  AST_FUNC_RESERVED: assert property (@(posedge clock) disable iff (!resetn)
    rd && addr == cgr_pkg::ADDR_PIN_FUNCTION_SELECT_REG |=> bus_rdata[7:4] == 4'h0)
    else $error("reserved configuration bits not zero");

  AST_ANALOG_NO_DRIVE: assert property (@(posedge clock) disable iff (!resetn)
    (pin_oe & pin_analog_en) == 4'h0)
    else $error("analog pin driven");

  AST_FUNC_RESET: assert property (@(posedge clock) !resetn |=> pin_analog_en == 4'hF)
    else $error("pins not analog after reset");

  AST_PIN_RESET: assert property (@(posedge clock) !resetn |=> pin_oe == 4'h0 && pin_out == 4'h0)
    else $error("pins driven after reset");

  AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!resetn)
    !rd |=> bus_rdata == cgr_pkg::READ_UNMAPPED)
    else $error("read data not zero between reads");

  AST_CORR_PULSE: assert property (@(posedge clock) disable iff (!resetn)
    !raw_sample.valid |-> ##2 !corr_sample.valid)
    else $error("corrected sample without raw sample");

  // The past reset term keeps the reset edge itself from counting as a change
  AST_CORR_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    $changed(corr_sample.value) && $past(resetn) |-> corr_sample.valid)
    else $error("corrected value changed without valid");
endmodule : cgr_regs

/* test/cgr_pin_env.sv */
// Far-side model of the four general-purpose pins
`timescale 1ns/1ps
module cgr_pin_env #(
  parameter int PIN_N = 4
) (
  input wire logic [PIN_N-1:0] pin_out, // Level the bank drives
  input wire logic [PIN_N-1:0] pin_oe, // High while the bank drives the pin
  input wire logic [PIN_N-1:0] ext_level, // Level an outside source drives
  output logic [PIN_N-1:0] pin_in // Level seen on the wire
);
  // A driven pin shows the bank's level; a released pin follows the outside source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : cgr_pin_env

/* test/cal_and_gpio_regs_tb.sv */
// Self-checking testbench of the calibration and pin register bank
`timescale 1ns/1ps
module cal_and_gpio_regs_tb;
  logic clock;
  logic resetn;
  cgr_pkg::cgr_bus_req_type bus_req;
  logic [7:0] bus_rdata;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic [3:0] pin_analog_en;
  logic [3:0] ext_level;
  cgr_pkg::cgr_sample_type raw_sample;
  cgr_pkg::cgr_sample_type corr_sample;
  cgr_pkg::cgr_trim_type trim;
  int miscompares;
  int n_checks;

  always #20 clock = ~clock;

  cgr_regs #(.PIN_N(4)) dut_u (
    .clock(clock),
    .resetn(resetn),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_analog_en(pin_analog_en),
    .raw_sample(raw_sample),
    .corr_sample(corr_sample),
    .trim(trim)
  );

  cgr_pin_env #(.PIN_N(4)) env_u (
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .ext_level(ext_level),
    .pin_in(pin_in)
  );

  task automatic close_out;
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clock);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    chk(what, {16'h0000, bus_rdata}, {16'h0000, exp});
  endtask : rd_chk

  task automatic reset_values;
    rd_chk("offset_cal_mid", 8'h0B, 8'h00);
    rd_chk("offset_cal_high", 8'h0C, 8'h00);
    rd_chk("gain_cal_low", 8'h0D, 8'h00);
    rd_chk("gain_cal_mid", 8'h0E, 8'h00);
    rd_chk("gain_cal_high", 8'h0F, 8'h40);
    rd_chk("pin_dir_and_level", 8'h10, 8'h00);
    rd_chk("pin_function_select_reg", 8'h11, 8'h00);
    chk("offset_trim_value", trim.offset_trim_value, 24'h000000);
    chk("gain_trim_value", trim.gain_trim_value, 24'h400000);
    chk("pin_analog_en", {20'h00000, pin_analog_en}, 24'h00000F);
  endtask : reset_values

  task automatic trim_rw;
    logic [7:0] pat [6];
    pat = '{8'h3C, 8'h5A, 8'hA5, 8'hC3, 8'h7E, 8'h81};
    for (int i = 0; i < 6; i++)
      wr_reg(8'h0A + 8'(i), pat[i]);
    for (int i = 0; i < 6; i++)
      rd_chk("trim byte", 8'h0A + 8'(i), pat[i]);
    @(posedge clock);
    #1;
    chk("read data after its cycle", {16'h0000, bus_rdata}, 24'h000000);
    chk("offset_trim_value", trim.offset_trim_value, 24'hA55A3C);
    chk("gain_trim_value", trim.gain_trim_value, 24'h817EC3);
    wr_reg(8'h12, 8'h55);
    rd_chk("unmapped", 8'h12, 8'h00);
  endtask : trim_rw

  task automatic pins;
    wr_reg(8'h10, 8'h05);
    chk("analog pin drive", {20'h00000, pin_oe}, 24'h000000);
    rd_chk("pin_dir_and_level analog", 8'h10, 8'h05);
    wr_reg(8'h11, 8'hFF);
    rd_chk("pin_function_select_reg", 8'h11, 8'h0F);
    chk("pin_analog_en", {20'h00000, pin_analog_en}, 24'h000000);
    chk("pin_oe outputs", {20'h00000, pin_oe}, 24'h00000F);
    chk("pin_out", {20'h00000, pin_out}, 24'h000005);
    rd_chk("pin_dir_and_level", 8'h10, 8'h05);
    // Outside level differs from both the written and the earlier driven level
    ext_level <= 4'h2;
    wr_reg(8'h10, 8'h6C);
    chk("pin_oe mixed", {20'h00000, pin_oe}, 24'h000009);
    chk("driven levels", {20'h00000, pin_out & pin_oe}, 24'h000008);
    repeat (3) @(posedge clock);
    #1;
    rd_chk("pin_dir_and_level mixed", 8'h10, 8'h6A);
    wr_reg(8'h10, 8'hF0);
    chk("pin_oe inputs", {20'h00000, pin_oe}, 24'h000000);
    repeat (3) @(posedge clock);
    #1;
    rd_chk("pin_dir_and_level inputs", 8'h10, 8'hF2);
  endtask : pins

  task automatic sample(input logic [23:0] raw, input logic [23:0] exp);
    raw_sample <= {1'b1, raw};
    @(posedge clock);
    raw_sample.valid <= 1'b0;
    #1;
    chk("corr valid early", {23'h000000, corr_sample.valid}, 24'h000000);
    @(posedge clock);
    #1;
    chk("corr valid", {23'h000000, corr_sample.valid}, 24'h000001);
    chk("corr value", corr_sample.value, exp);
    @(posedge clock);
    #1;
    chk("corr valid one cycle", {23'h000000, corr_sample.valid}, 24'h000000);
    chk("corr value held", corr_sample.value, exp);
  endtask : sample

  task automatic correction;
    logic [7:0] half [6];
    half = '{8'h0A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
    for (int i = 0; i < 6; i++)
      wr_reg(8'h0A + 8'(i), half[i]);
    // Offset 10 and gain one half
    sample(24'h000064, 24'h00002D);
    for (int i = 0; i < 3; i++)
      wr_reg(8'h0A + 8'(i), 8'hFF);
    wr_reg(8'h0F, 8'h40);
    wr_reg(8'h0E, 8'h00);
    rd_chk("gain_cal_mid", 8'h0E, 8'h00);
    // Removing an offset of -1 from full scale must clip, not wrap
    sample(24'h7FFFFF, 24'h7FFFFF);
  endtask : correction

  task automatic mid_reset;
    wr_reg(8'h10, 8'h0F);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    chk("offset after reset", trim.offset_trim_value, 24'h000000);
    chk("gain after reset", trim.gain_trim_value, 24'h400000);
    chk("pin_oe after reset", {20'h00000, pin_oe}, 24'h000000);
    chk("pin_out after reset", {20'h00000, pin_out}, 24'h000000);
    chk("pin_analog_en after reset", {20'h00000, pin_analog_en}, 24'h00000F);
    rd_chk("gain_cal_high after reset", 8'h0F, 8'h40);
    // Reset trims are unity, so the sample must pass unchanged
    sample(24'h123456, 24'h123456);
  endtask : mid_reset

  initial
  begin
    clock = 1'b0;
    resetn = 1'b0;
    bus_req = '0;
    ext_level = 4'h0;
    raw_sample = '0;
    miscompares = 0;
    n_checks = 0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    reset_values();
    trim_rw();
    pins();
    correction();
    mid_reset();
    close_out();
  end
endmodule : cal_and_gpio_regs_tb
